// ==== core/memory_map_reset_clock.sv ====
`include "mmrc_cfg.svh"

module memory_map_reset_clock #(
  parameter int RESET_MIN_ST   = `RESET_MIN_ST,
  parameter int RESET_SEQ_ST   = `RESET_SEQ_ST,
  parameter int RESET_DRIVE_ST = `RESET_DRIVE_ST
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  // reset pin, open drain
  input  wire logic              resetPinIn,
  output logic                   resetPinOut,
  output logic                   resetPinOe_n,
  input  wire logic              pullResetReq,
  output logic                   coreReset,
  // clock output
  output logic                   dividedClockOutput,
  output logic                   stateTimeTick,
  // pins
  input  wire logic              externalAccessSelect,
  input  wire logic              busWidthPin,
  input  wire logic              nmiPin,
  input  wire logic [7:0]        chipConfigByteIn,
  // core access decode
  input  wire mmrc_pkg::access_t acc,
  output mmrc_pkg::decode_t      decOut,
  output logic                   decValid,
  output logic                   busCycle16,
  output logic                   reservedHit,
  // non-maskable interrupt vector request
  output logic                   nmiVectorReq,
  output logic [15:0]            nmiVectorAddr,
  // register port
  input  wire logic [15:0]       regAddr,
  input  wire logic [7:0]        regWdata,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic [7:0]             regRdata
);

  localparam int STC = `STATE_TIME_CLKS;

  logic [3:0]              pinSync;
  logic                    rstPinS;
  logic                    eaS;
  logic                    bwS;
  logic                    nmiS;
  logic                    nmiPrevReg;
  logic                    clkoutReg;
  logic                    clkoutNext;
  logic                    realign;
  mmrc_pkg::rst_state_t    stateReg;
  mmrc_pkg::rst_state_t    stateNext;
  logic [3:0]              lowCntReg;
  logic [3:0]              lowCntNext;
  logic [3:0]              seqCntReg;
  logic [3:0]              seqCntNext;
  logic [3:0]              drvCntReg;
  logic                    lowQualified;
  logic                    seqDone;
  logic                    coreResetNext;
  logic                    ccbLoad;
  logic [7:0]              ccrReg;
  logic                    nmiPendReg;
  logic                    nmiEdge;
  logic                    nmiClr;
  mmrc_pkg::decode_t       decComb;
  logic                    busWideSel;
  logic                    selCcr;
  logic                    selStatus;
  logic                    selCcb;
  logic [7:0]              statusVal;
  logic [7:0]              rdMux;

  // reset, access select, bus width and NMI pins pass two flip-flops; the config byte is used unsynchronised
  sync2 #(
    .W         (4),
    .RESET_VAL (4'h1)
  ) u_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn ({nmiPin, busWidthPin, externalAccessSelect, resetPinIn}),
    .syncOut (pinSync)
  );

  assign rstPinS = pinSync[0];
  assign eaS     = pinSync[1];
  assign bwS     = pinSync[2];
  assign nmiS    = pinSync[3];

  // clock divider, toggles every oscillator cycle except when realigned low at release of a qualified reset pin
  assign clkoutNext    = realign ? 1'b0 : !clkoutReg;
  assign stateTimeTick = clkoutReg;                          // one pulse per state time

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clkoutReg <= 1'b0;
    end else begin
      clkoutReg <= clkoutNext;
    end
  end

  assign dividedClockOutput = clkoutReg;

  // reset pin qualification and internal sequence
  assign lowQualified = lowCntReg >= 4'(RESET_MIN_ST);
  assign seqDone      = stateTimeTick && seqCntReg == 4'(RESET_SEQ_ST - 1);
  assign realign      = stateReg == mmrc_pkg::RS_PIN_LOW && rstPinS && lowQualified;

  always_comb begin
    stateNext  = stateReg;
    lowCntNext = lowCntReg;
    seqCntNext = seqCntReg;
    unique case (stateReg)
      mmrc_pkg::RS_RUN: begin
        if (!rstPinS) begin
          // first low sample counts only if it falls on a tick, yet four state times of low always qualify
          stateNext  = mmrc_pkg::RS_PIN_LOW;
          lowCntNext = stateTimeTick ? 4'h1 : 4'h0;
        end
      end
      mmrc_pkg::RS_PIN_LOW: begin
        if (rstPinS) begin
          // short pulses are ignored
          stateNext  = lowQualified ? mmrc_pkg::RS_SEQ : mmrc_pkg::RS_RUN;
          seqCntNext = 4'h0;
        end else if (stateTimeTick && !lowQualified) begin
          lowCntNext = lowCntReg + 4'h1;
        end
      end
      mmrc_pkg::RS_SEQ: begin
        if (!rstPinS) begin
          stateNext  = mmrc_pkg::RS_PIN_LOW;
          lowCntNext = 4'h0;
        end else if (seqDone) begin
          stateNext = mmrc_pkg::RS_RUN;
        end else if (stateTimeTick) begin
          seqCntNext = seqCntReg + 4'h1;
        end
      end
    endcase
  end

  assign coreResetNext = stateNext == mmrc_pkg::RS_SEQ ||
                         (stateNext == mmrc_pkg::RS_PIN_LOW && lowCntNext >= 4'(RESET_MIN_ST));
  assign ccbLoad       = stateReg == mmrc_pkg::RS_SEQ && seqDone;

  // chip reset starts a sequence of its own
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stateReg  <= mmrc_pkg::RS_SEQ;
      lowCntReg <= 4'h0;
      seqCntReg <= 4'h0;
      coreReset <= 1'b1;
    end else begin
      stateReg  <= stateNext;
      lowCntReg <= lowCntNext;
      seqCntReg <= seqCntNext;
      coreReset <= coreResetNext;
    end
  end

  // open-drain pull-down on request, never driven high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drvCntReg <= 4'h0;
    end else if (pullResetReq && drvCntReg == 4'h0) begin
      drvCntReg <= 4'(RESET_DRIVE_ST * STC);
    end else if (drvCntReg != 4'h0) begin
      drvCntReg <= drvCntReg - 4'h1;
    end
  end

  assign resetPinOut  = 1'b0;
  assign resetPinOe_n = drvCntReg == 4'h0;

  // non-maskable interrupt edge and pending flag
  assign nmiEdge = nmiS && !nmiPrevReg && !coreReset;
  assign nmiClr  = regWrite && regAddr == `NMICLR_OFF && regWdata[`NMICLR_BIT];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nmiPrevReg   <= 1'b0;
      nmiPendReg   <= 1'b0;
      nmiVectorReq <= 1'b0;
    end else begin
      nmiPrevReg   <= nmiS;
      nmiVectorReq <= nmiEdge;
      // a new edge wins over a clear in the same cycle
      if (nmiEdge) begin
        nmiPendReg <= 1'b1;
      end else if (nmiClr) begin
        nmiPendReg <= 1'b0;
      end
    end
  end

  assign nmiVectorAddr = `NMI_VECTOR;

  // configuration register, loaded from the config byte at sequence end
  assign selCcr    = regAddr == `CCR_OFF;
  assign selStatus = regAddr == `STATUS_OFF;
  assign selCcb    = regAddr == `CCB_OFF;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ccrReg <= `CCR_RESET;
    end else if (ccbLoad) begin
      ccrReg <= chipConfigByteIn;
    end else if (regWrite && selCcr) begin
      ccrReg <= regWdata;
    end
  end

  // address decode of the core access
  addr_decode u_dec (
    .eaHigh (eaS),
    .acc    (acc),
    .dec    (decComb)
  );

  // bus width per external cycle
  assign busWideSel = ccrReg[`CCR_BUSW_BIT] ? bwS : 1'b0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      decOut      <= '0;
      decValid    <= 1'b0;
      busCycle16  <= 1'b0;
      reservedHit <= 1'b0;
    end else begin
      decValid    <= acc.valid && !coreReset;
      decOut      <= decComb;
      busCycle16  <= acc.valid && decComb.external && busWideSel;
      reservedHit <= acc.valid && decComb.reserved;
    end
  end

  // status and read mux
  always_comb begin
    statusVal                   = 8'h00;
    statusVal[`ST_CORE_RST_BIT] = coreReset;
    statusVal[`ST_EA_BIT]       = eaS;
    statusVal[`ST_BUSW_BIT]     = bwS;
    statusVal[`ST_NMI_BIT]      = nmiPendReg;
    statusVal[`ST_DIVIDED_CLOCK_OUTPUT_BIT]   = clkoutReg;
    statusVal[`ST_PIN_DRV_BIT]  = !resetPinOe_n;
  end

  assign rdMux = selCcr    ? ccrReg :
                 selStatus ? statusVal :
                 selCcb    ? chipConfigByteIn :
                 8'h00;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= regRead ? rdMux : 8'h00;
    end
  end

endmodule

// ==== core/mmrc_cfg.svh ====
`ifndef MMRC_CFG_SVH
`define MMRC_CFG_SVH

// oscillator and state time
`define OSC_PERIOD_NS     20
`define STATE_TIME_NS     40
`define STATE_TIME_CLKS   (`STATE_TIME_NS / `OSC_PERIOD_NS)

// reset timing in state times
`define RESET_MIN_ST      4
`define RESET_SEQ_ST      10
`define RESET_DRIVE_ST    4

// register port offsets
`define CCR_OFF           16'h0000
`define STATUS_OFF        16'h0002
`define NMICLR_OFF        16'h0004
`define CCB_OFF           16'h2018

// register reset values
`define CCR_RESET         8'h00

// field positions
`define CCR_BUSW_BIT      1
`define ST_CORE_RST_BIT   0
`define ST_EA_BIT         1
`define ST_BUSW_BIT       2
`define ST_NMI_BIT        3
`define ST_DIVIDED_CLOCK_OUTPUT_BIT     4
`define ST_PIN_DRV_BIT    5
`define NMICLR_BIT        0

// memory map bounds
`define MAP_SFR_END       16'h0017
`define MAP_RAM_END       16'h00FF
`define MAP_EXTLO_END     16'h1FFD
`define MAP_PORTS_END     16'h1FFF
`define MAP_VECLO_END     16'h2013
`define MAP_RSV1_END      16'h2017
`define MAP_CCB_ADDR      16'h2018
`define MAP_RSV2_END      16'h201F
`define MAP_KEY_END       16'h202F
`define MAP_VECHI_END     16'h203F
`define MAP_RSV3_END      16'h207F
`define MAP_PROG_END      16'h3FFF

// vector fetched on a non-maskable interrupt
`define NMI_VECTOR        16'h203E

`endif

// ==== core/mmrc_pkg.sv ====
package mmrc_pkg;

  typedef enum logic [3:0] {
    RG_SFR, RG_RAM, RG_EXT, RG_PORTS, RG_VEC_LO, RG_RSVD,
    RG_CCB, RG_KEY, RG_VEC_HI, RG_PROG
  } region_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        valid;
    logic        fetch;
  } access_t;

  typedef struct packed {
    region_t region;
    logic    external;
    logic    reserved;
  } decode_t;

  typedef enum logic [1:0] {RS_RUN, RS_PIN_LOW, RS_SEQ} rst_state_t;

endpackage

// ==== core/sync2.sv ====
module sync2 #(
  parameter int          W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] stage1Reg;

  // two flip-flop synchroniser, first stage read only by second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1Reg <= RESET_VAL;
      syncOut   <= RESET_VAL;
    end else begin
      stage1Reg <= asyncIn;
      syncOut   <= stage1Reg;
    end
  end

endmodule

// ==== core/addr_decode.sv ====
`include "mmrc_cfg.svh"

module addr_decode (
  input  wire logic             eaHigh,
  input  wire mmrc_pkg::access_t acc,
  output mmrc_pkg::decode_t      dec
);

  logic [15:0] a;
  logic        inSfr;
  logic        inRam;
  logic        inExtLo;
  logic        inPorts;
  logic        inVecLo;
  logic        inRsv1;
  logic        inCcb;
  logic        inRsv2;
  logic        inKey;
  logic        inVecHi;
  logic        inRsv3;
  logic        inProg;
  logic        inEaWin;

  // range compares over the 64 KB space
  assign a       = acc.addr;
  assign inSfr   = a <= `MAP_SFR_END;
  assign inRam   = !inSfr && a <= `MAP_RAM_END;
  assign inExtLo = a > `MAP_RAM_END && a <= `MAP_EXTLO_END;
  assign inPorts = a > `MAP_EXTLO_END && a <= `MAP_PORTS_END;
  assign inVecLo = a > `MAP_PORTS_END && a <= `MAP_VECLO_END;
  assign inRsv1  = a > `MAP_VECLO_END && a <= `MAP_RSV1_END;
  assign inCcb   = a == `MAP_CCB_ADDR;
  assign inRsv2  = a > `MAP_CCB_ADDR && a <= `MAP_RSV2_END;
  assign inKey   = a > `MAP_RSV2_END && a <= `MAP_KEY_END;
  assign inVecHi = a > `MAP_KEY_END && a <= `MAP_VECHI_END;
  assign inRsv3  = a > `MAP_VECHI_END && a <= `MAP_RSV3_END;
  assign inProg  = a > `MAP_RSV3_END && a <= `MAP_PROG_END;
  assign inEaWin = a > `MAP_PORTS_END && a <= `MAP_PROG_END;

  // region code
  assign dec.region = inSfr   ? mmrc_pkg::RG_SFR :
                      inRam   ? mmrc_pkg::RG_RAM :
                      inExtLo ? mmrc_pkg::RG_EXT :
                      inPorts ? mmrc_pkg::RG_PORTS :
                      inVecLo ? mmrc_pkg::RG_VEC_LO :
                      inCcb   ? mmrc_pkg::RG_CCB :
                      inKey   ? mmrc_pkg::RG_KEY :
                      inVecHi ? mmrc_pkg::RG_VEC_HI :
                      inProg  ? mmrc_pkg::RG_PROG :
                      (inRsv1 || inRsv2 || inRsv3) ? mmrc_pkg::RG_RSVD :
                      mmrc_pkg::RG_EXT;

  // where the access is carried out
  assign dec.external = ((inSfr || inRam) && acc.fetch) ||
                        inExtLo ||
                        (inEaWin && !eaHigh) ||
                        a > `MAP_PROG_END;

  // reserved locations are flagged but not blocked; decValid is set for them as for any access
  assign dec.reserved = inRsv1 || inRsv2 || inRsv3;
endmodule

// ==== tb/mmrc_props.sv ====
module mmrc_props (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              resetPinIn,
  input wire logic              resetPinOut,
  input wire logic              resetPinOe_n,
  input wire logic              pullResetReq,
  input wire logic              coreReset,
  input wire logic              dividedClockOutput,
  input wire logic              nmiPin,
  input wire mmrc_pkg::access_t acc,
  input wire mmrc_pkg::decode_t decOut,
  input wire logic              busCycle16,
  input wire logic              nmiVectorReq,
  input wire logic [15:0]       nmiVectorAddr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // clock output and reset pin
  property p_clkHalf;
    !coreReset && $past(!coreReset) |-> dividedClockOutput != $past(dividedClockOutput);
  endproperty
  a_clkHalf: assert property (p_clkHalf) else $error("clock output stalled");
  property p_pinLow;
    resetPinOut == 1'b0;
  endproperty
  a_pinLow: assert property (p_pinLow) else $error("reset pin driven high");
  property p_pull;
    pullResetReq && resetPinOe_n |=> !resetPinOe_n [*8] ##1 resetPinOe_n;
  endproperty
  a_pull: assert property (p_pull) else $error("reset pull length wrong");
  property p_qualify;
    $rose(coreReset) |-> !$past(resetPinIn, 3) && !$past(resetPinIn, 6);
  endproperty
  a_qualify: assert property (p_qualify) else $error("reset without long low");
  // reset sequence after the pin is released
  sequence s_pinRise;
    coreReset && $rose(resetPinIn);
  endsequence
  sequence s_hold16;
    coreReset [*8] ##1 coreReset [*8];
  endsequence
  property p_resetSeq;
    s_pinRise |-> s_hold16 ##[1:14] !coreReset;
  endproperty
  a_resetSeq: assert property (p_resetSeq) else $error("reset sequence length wrong");
  // bus width and interrupt vector
  property p_bus16;
    busCycle16 |-> decOut.external;
  endproperty
  a_bus16: assert property (p_bus16) else $error("wide cycle on internal access");
  property p_nmi;
    nmiVectorReq |-> $past(nmiPin, 3) && !$past(nmiPin, 4) ##1 !nmiVectorReq;
  endproperty
  a_nmi: assert property (p_nmi) else $error("vector request without edge");
  property p_nmiAddr;
    nmiVectorAddr == 16'h203E;
  endproperty
  a_nmiAddr: assert property (p_nmiAddr) else $error("wrong vector address");
  // address decode
  property p_decExt;
    acc.valid && acc.addr >= 16'h4000 |=> decOut.external && decOut.region == mmrc_pkg::RG_EXT;
  endproperty
  a_decExt: assert property (p_decExt) else $error("high space not external");
  property p_decProg;
    acc.valid && acc.addr inside {[16'h2080:16'h3FFF]} |=> decOut.region == mmrc_pkg::RG_PROG;
  endproperty
  a_decProg: assert property (p_decProg) else $error("program window misdecoded");
  property p_decLow;
    acc.valid && acc.addr <= 16'h00FF |=> decOut.external == $past(acc.fetch)
      && decOut.region == ($past(acc.addr) <= 16'h0017 ? mmrc_pkg::RG_SFR : mmrc_pkg::RG_RAM);
  endproperty
  a_decLow: assert property (p_decLow) else $error("low space misdecoded");
endmodule

// ==== tb/ext_reset_src.sv ====
module ext_reset_src (
  input  wire logic clk,
  input  wire logic devOe_n,
  output wire logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic srcLow = 1'b0;
  // pull-up on the pin, any party pulling low wins
  assign pin = !(srcLow || !devOe_n);
  // outside reset source holds the pin low n cycles
  task hold(input int n);
    @(posedge clk);
    srcLow <= 1'b1;
    repeat (n) @(posedge clk);
    srcLow <= 1'b0;
  endtask
endmodule

// ==== tb/memory_map_reset_clock_bench.sv ====
module memory_map_reset_clock_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk, rst_n, pullReq, eaPin, bwPin, nmiPin, regWrite, regRead;
  logic              pinOut, pinOe_n, coreReset, divClk, tick, decValid, bus16, rsvHit, nmiReq;
  logic [15:0]       regAddr, nmiAddr;
  logic [7:0]        regWdata, cfgByte, rdv, regRdata;
  wire logic         pinLevel;
  mmrc_pkg::access_t acc;
  mmrc_pkg::decode_t decOut;
  int                n_errors, checks_done, cnt;
  int                cyc = 0;
  logic [15:0]       addrs [17] = '{16'h0000, 16'h0017, 16'h0018, 16'h00FF, 16'h0100, 16'h1FFD,
    16'h1FFE, 16'h2000, 16'h2014, 16'h2018, 16'h2019, 16'h2030, 16'h2040, 16'h2080, 16'h3FFF,
    16'h4000, 16'hFFFF};

  memory_map_reset_clock u_dut (.clk(clk), .rst_n(rst_n), .resetPinIn(pinLevel),
    .resetPinOut(pinOut), .resetPinOe_n(pinOe_n), .pullResetReq(pullReq), .coreReset(coreReset),
    .dividedClockOutput(divClk), .stateTimeTick(tick), .externalAccessSelect(eaPin),
    .busWidthPin(bwPin), .nmiPin(nmiPin), .chipConfigByteIn(cfgByte), .acc(acc),
    .decOut(decOut), .decValid(decValid), .busCycle16(bus16), .reservedHit(rsvHit),
    .nmiVectorReq(nmiReq), .nmiVectorAddr(nmiAddr), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
  ext_reset_src u_src (.clk(clk), .devOe_n(pinOe_n), .pin(pinLevel));

  // clock and timeout
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      end_sim();
    end
  end

  task end_sim();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // register port cycles
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task rd(input logic [15:0] a);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 rdv = regRdata;
  endtask
  task rdChk(input logic [15:0] a, input logic [7:0] e);
    rd(a);
    chk(rdv, e);
  endtask
  task waitCore(input logic v, input int n);
    for (int i = 0; i < n && coreReset !== v; i++) @(posedge clk) #1;
  endtask
  function automatic logic [3:0] expReg(input logic [15:0] a);
    if (a <= 16'h0017) return mmrc_pkg::RG_SFR;
    if (a <= 16'h00FF) return mmrc_pkg::RG_RAM;
    if (a <= 16'h1FFD) return mmrc_pkg::RG_EXT;
    if (a <= 16'h1FFF) return mmrc_pkg::RG_PORTS;
    if (a <= 16'h2013) return mmrc_pkg::RG_VEC_LO;
    if (a == 16'h2018) return mmrc_pkg::RG_CCB;
    if (a <= 16'h201F) return mmrc_pkg::RG_RSVD;
    if (a <= 16'h202F) return mmrc_pkg::RG_KEY;
    if (a <= 16'h203F) return mmrc_pkg::RG_VEC_HI;
    if (a <= 16'h207F) return mmrc_pkg::RG_RSVD;
    if (a <= 16'h3FFF) return mmrc_pkg::RG_PROG;
    return mmrc_pkg::RG_EXT;
  endfunction
  // one decode sample and its expected result
  task decChk(input logic [15:0] a, input logic f);
    logic [3:0] r;
    logic       e;
    logic       s;
    r = expReg(a);
    s = r == mmrc_pkg::RG_RSVD;
    e = r == mmrc_pkg::RG_EXT || (a inside {[16'h2000:16'h3FFF]} && !eaPin) || (f && a <= 16'h00FF);
    @(posedge clk);
    acc <= '{addr: a, valid: 1'b1, fetch: f};
    @(posedge clk);
    acc.valid <= 1'b0;
    #1 chk({10'h000, decOut}, {10'h000, r, e, s});
    chk({rsvHit, decValid}, {s, 1'b1});
  endtask
  task busChk(input logic [7:0] chip_config_register, input logic bw, input logic exp);
    wr(16'h0000, chip_config_register);
    bwPin <= bw;
    repeat (4) @(posedge clk);
    decChk(16'h4000, 1'b0);
    chk(bus16, exp);
    chk(tick, divClk);
  endtask

  // main sequence
  initial begin
    {rst_n, pullReq, nmiPin, regWrite, regRead} = '0;
    {eaPin, bwPin} = 2'b11;
    {regAddr, regWdata, acc} = '0;
    cfgByte = 8'h02;
    n_errors = 0;
    checks_done = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    waitCore(1'b0, 60);
    chk(coreReset, 1'b0);
    rdChk(16'h2018, 8'h02);
    rdChk(16'h0000, 8'h02);
    rdChk(16'h0006, 8'h00);
    wr(16'h2018, 8'h55);
    rdChk(16'h2018, 8'h02);
    $display("test registers done");
    for (int k = 0; k < 2; k++) begin
      eaPin <= k == 0;
      repeat (4) @(posedge clk);
      foreach (addrs[i]) decChk(addrs[i], 1'b0);
    end
    decChk(16'h0010, 1'b1);
    decChk(16'h00FF, 1'b1);
    busChk(8'h02, 1'b1, 1'b1);
    busChk(8'h02, 1'b0, 1'b0);
    busChk(8'h00, 1'b1, 1'b0);
    $display("test decode done");
    nmiPin <= 1'b1;
    for (int i = 0; i < 10 && nmiReq !== 1'b1; i++) @(posedge clk) #1;
    chk(nmiReq, 1'b1);
    chk(nmiAddr, 16'h203E);
    rd(16'h0002);
    chk(rdv[3], 1'b1);
    wr(16'h0004, 8'h01);
    rd(16'h0002);
    chk(rdv[3], 1'b0);
    nmiPin <= 1'b0;
    $display("test interrupt done");
    @(posedge clk);
    pullReq <= 1'b1;
    @(posedge clk);
    pullReq <= 1'b0;
    cnt = 0;
    #1 repeat (12) begin
      cnt += !pinOe_n;
      @(posedge clk) #1;
    end
    chk(cnt, 8);
    chk(coreReset, 1'b1);
    waitCore(1'b0, 60);
    chk(coreReset, 1'b0);
    $display("test pin pull done");
    wr(16'h0000, 8'h00);
    u_src.hold(5);
    waitCore(1'b1, 20);
    chk(coreReset, 1'b0);
    u_src.hold(10);
    waitCore(1'b1, 20);
    chk(coreReset, 1'b1);
    waitCore(1'b0, 60);
    chk(coreReset, 1'b0);
    rdChk(16'h0000, 8'h02);
    $display("test outside reset done");
    end_sim();
  end
endmodule

bind memory_map_reset_clock mmrc_props u_props (.clk, .rst_n, .resetPinIn, .resetPinOut,
  .resetPinOe_n, .pullResetReq, .coreReset, .dividedClockOutput, .nmiPin, .acc, .decOut,
  .busCycle16, .nmiVectorReq, .nmiVectorAddr);
